// File: tch_regs.svh
// Register offsets, field positions, reset values, auto reset periods in seconds and the clock rate.
`ifndef TCH_REGS_SVH
`define TCH_REGS_SVH
`define TCH_OFF_MODE 8'h00
`define TCH_OFF_ADDR 8'h01
`define TCH_OFF_FEAT 8'h02
`define TCH_MODE_RESTORE_BIT 5
`define TCH_MODE_MATCH_BIT 4
`define TCH_MODE_SAVE_BIT 3
`define TCH_MODE_RST 8'h02
`define TCH_ADDR_RST 8'h37
`define TCH_FEAT_RST 8'h02
`define TCH_FEAT_AUTO_RESET_PERIOD_HI 3
`define TCH_FEAT_AUTO_RESET_PERIOD_LO 2
`define TCH_FEAT_AUTO_BIT 1
`define TCH_FEAT_NOISE_BIT 0
`define TCH_AUTO_RESET_PERIOD_SHORT_S 5
`define TCH_AUTO_RESET_PERIOD_LONG_S 20
`define TCH_CLK_HZ 200000000
`endif

// File: tch_pkg.sv
// Types shared by the touch configuration register block.
package tch_pkg;
    typedef enum logic [2:0] {
        TCH_MODE_NORMAL = 3'h0,
        TCH_MODE_LED_CFG = 3'h1,
        TCH_MODE_DEV_CFG = 3'h2,
        TCH_MODE_LINE_TEST = 3'h3,
        TCH_MODE_DEBUG = 3'h4
    } tch_mode_type;

    // One register access from the serial slave front end.
    typedef struct packed {
        logic wr;
        logic rd;
        logic [7:0] addr;
        logic [7:0] wdata;
    } tch_req_type;

    // Settings presented to the sensing logic.
    typedef struct packed {
        logic [2:0] mode;
        logic mode_valid;
        logic [6:0] slave_addr;
        logic [1:0] auto_reset_period;
        logic auto_threshold;
        logic noise_immunity_level;
    } tch_cfg_type;
endpackage : tch_pkg

// File: tch_cmd_seq.sv
// Sequencer for write_clear commands: restore and save handshakes.
`timescale 1ns/100ps
`default_nettype none
module tch_cmd_seq (
    // Clock and reset.
    input wire logic ref_clk_in,
    input wire logic reset_in,
    // Command start pulse and external completion.
    input wire logic start_in,
    input wire logic done_in,
    // Request level and busy bit.
    output logic req_out,
    output logic busy_out
);
    import tch_pkg::*;

    typedef enum logic [1:0] {TCH_SEQ_IDLE, TCH_SEQ_REQ, TCH_SEQ_WAIT}
        tch_seq_type;
    tch_seq_type state_reg;
    tch_seq_type state_next;

    // =================================================================
    // Next state: request held until the operation reports completion.
    always_comb begin
        state_next = state_reg;
        case (state_reg)
            TCH_SEQ_IDLE: begin
                if (start_in) begin
                    state_next = TCH_SEQ_REQ;
                end
            end
            TCH_SEQ_REQ: begin
                if (done_in) begin
                    state_next = TCH_SEQ_IDLE;
                end else begin
                    state_next = TCH_SEQ_WAIT;
                end
            end
            TCH_SEQ_WAIT: begin
                if (done_in) begin
                    state_next = TCH_SEQ_IDLE;
                end
            end
            default: begin
                state_next = TCH_SEQ_IDLE;
            end
        endcase
    end

    // State register.
    always_ff @(posedge ref_clk_in or posedge reset_in) begin
        if (reset_in) begin
            state_reg <= TCH_SEQ_IDLE;
        end else begin
            state_reg <= state_next;
        end
    end

    assign req_out = (state_reg != TCH_SEQ_IDLE);
    assign busy_out = (state_reg != TCH_SEQ_IDLE);
endmodule : tch_cmd_seq
`default_nettype wire

// File: tch_cfg_regs.sv
// Host configuration registers of the ten-button touch controller.
`timescale 1ns/100ps
`default_nettype none
`include "tch_regs.svh"

module tch_cfg_regs #(
    parameter int unsigned CLK_HZ = `TCH_CLK_HZ
) (
    // Clock and reset.
    input wire logic ref_clk_in,
    input wire logic reset_in,
    // Register access from the serial slave front end.
    input wire tch_pkg::tch_req_type req_in,
    output logic [7:0] rdata_out,
    // Checksum comparison from the configuration engine.
    input wire logic [15:0] host_checksum_in,
    input wire logic [15:0] calc_checksum_in,
    // Storage and restore handshakes.
    output logic save_req_out,
    input wire logic save_done_in,
    output logic restore_req_out,
    input wire logic restore_done_in,
    // Restored working values supplied by the defaults table.
    input wire logic [7:0] default_addr_in,
    input wire logic [7:0] default_feat_in,
    // Settings and derived timing to the sensing logic.
    output tch_pkg::tch_cfg_type cfg_out,
    output logic [31:0] auto_reset_cycles_out
);
    import tch_pkg::*;

    localparam logic [31:0] SHORT_CYCLES =
        32'(`TCH_AUTO_RESET_PERIOD_SHORT_S * CLK_HZ);
    localparam logic [31:0] LONG_CYCLES =
        32'(64'(`TCH_AUTO_RESET_PERIOD_LONG_S) * 64'(CLK_HZ));

    // =================================================================
    // Register state.
    logic [2:0] mode_reg;
    logic [6:0] addr_reg;
    logic [3:0] feat_reg;
    logic match_reg;
    logic [7:0] rdata_reg;
    logic save_busy;
    logic restore_busy;

    // =================================================================
    // Address decode.
    wire hit_mode = req_in.addr == `TCH_OFF_MODE;
    wire hit_addr = req_in.addr == `TCH_OFF_ADDR;
    wire hit_feat = req_in.addr == `TCH_OFF_FEAT;
    wire wr_mode = req_in.wr && hit_mode;
    wire wr_addr = req_in.wr && hit_addr;
    wire wr_feat = req_in.wr && hit_feat;
    wire save_start = wr_mode && req_in.wdata[`TCH_MODE_SAVE_BIT];
    wire restore_start =
        wr_mode && req_in.wdata[`TCH_MODE_RESTORE_BIT];

    // Returns the cycle count for an auto reset code; zero means no limit.
    function automatic logic [31:0] auto_reset_period_cycles(input logic [1:0] code);
        case (code)
            2'h2: auto_reset_period_cycles = SHORT_CYCLES;
            2'h3: auto_reset_period_cycles = LONG_CYCLES;
            default: auto_reset_period_cycles = 32'h0;
        endcase
    endfunction : auto_reset_period_cycles

    // =================================================================
    // Command sequencers, one per write_clear bit.
    tch_cmd_seq u_save_seq (
        .ref_clk_in(ref_clk_in),
        .reset_in(reset_in),
        .start_in(save_start),
        .done_in(save_done_in),
        .req_out(save_req_out),
        .busy_out(save_busy)
    );

    tch_cmd_seq u_restore_seq (
        .ref_clk_in(ref_clk_in),
        .reset_in(reset_in),
        .start_in(restore_start),
        .done_in(restore_done_in),
        .req_out(restore_req_out),
        .busy_out(restore_busy)
    );

    // =================================================================
    // Mode field. Invalid codes are stored as written; the host owns
    // their consequences, and mode_valid lets the core ignore them.
    always_ff @(posedge ref_clk_in or posedge reset_in) begin
        if (reset_in) begin
            mode_reg <= 3'(`TCH_MODE_RST);
        end else if (wr_mode) begin
            mode_reg <= req_in.wdata[2:0];
        end
    end

    // Address and feature fields. A restore reloads only these working
    // copies; storage itself is untouched by this path.
    always_ff @(posedge ref_clk_in or posedge reset_in) begin
        if (reset_in) begin
            addr_reg <= 7'(`TCH_ADDR_RST);
            feat_reg <= 4'(`TCH_FEAT_RST);
        end else if (restore_busy && restore_done_in) begin
            addr_reg <= default_addr_in[6:0];
            feat_reg <= default_feat_in[3:0];
        end else begin
            if (wr_addr) begin
                addr_reg <= req_in.wdata[6:0];
            end
            if (wr_feat) begin
                feat_reg <= req_in.wdata[3:0];
            end
        end
    end

    // Checksum flag follows the comparison only; host writes never land.
    always_ff @(posedge ref_clk_in or posedge reset_in) begin
        if (reset_in) begin
            match_reg <= 1'b1;
        end else begin
            match_reg <= host_checksum_in == calc_checksum_in;
        end
    end

    // =================================================================
    // Read mux. Command bits read as one while busy and drop on their
    // own when the sequencer returns idle.
    wire [7:0] mode_view = {2'h0, restore_busy, match_reg, save_busy,
        mode_reg};
    wire [7:0] rdata_next = hit_mode ? mode_view :
        hit_addr ? {1'b0, addr_reg} :
        hit_feat ? {4'h0, feat_reg} : 8'h00;

    always_ff @(posedge ref_clk_in or posedge reset_in) begin
        if (reset_in) begin
            rdata_reg <= 8'h00;
        end else if (req_in.rd) begin
            rdata_reg <= rdata_next;
        end
    end

    // =================================================================
    // Settings out.
    assign rdata_out = rdata_reg;
    assign cfg_out.mode = mode_reg;
    assign cfg_out.mode_valid = mode_reg <= 3'h4;
    assign cfg_out.slave_addr = addr_reg;
    assign cfg_out.auto_reset_period = feat_reg[3:2];
    assign cfg_out.auto_threshold = feat_reg[1];
    assign cfg_out.noise_immunity_level = feat_reg[0];
    assign auto_reset_cycles_out = auto_reset_period_cycles(feat_reg[3:2]);
endmodule : tch_cfg_regs
`default_nettype wire

// File: tch_properties.sv
// Concurrent checks at the configuration register ports.
`timescale 1ns/100ps
`default_nettype none
module tch_props #(parameter int unsigned CLK_HZ = 100) (
    // Watched ports.
    input wire logic ref_clk_in,
    input wire logic reset_in,
    input wire tch_pkg::tch_req_type req_in,
    input wire logic [7:0] rdata_out,
    input wire logic save_req_out,
    input wire logic save_done_in,
    input wire logic restore_req_out,
    input wire logic restore_done_in,
    input wire logic [7:0] default_addr_in,
    input wire tch_pkg::tch_cfg_type cfg_out,
    input wire logic [31:0] auto_reset_cycles_out
);
    import tch_pkg::*;
    default clocking @(posedge ref_clk_in); endclocking
    default disable iff (reset_in);
    // Decoded host writes to the mode register.
    wire logic wr0 = req_in.wr && req_in.addr == 8'h00;
    sequence s_rst_done;
        restore_req_out && restore_done_in;
    endsequence
    a_save_start: assert property (
        wr0 && req_in.wdata[3] |=> save_req_out) else $error("no save");
    a_save_clear: assert property (
        save_req_out && save_done_in && !wr0 |=> !save_req_out)
        else $error("save stuck");
    a_restore_load: assert property (
        s_rst_done |=> cfg_out.slave_addr == $past(default_addr_in[6:0]))
        else $error("restore lost");
    a_mode_write: assert property (wr0 |=>
        cfg_out.mode == $past(req_in.wdata[2:0]) &&
        cfg_out.mode_valid == ($past(req_in.wdata[2:0]) < 3'h5))
        else $error("mode");
    a_feat_write: assert property (
        req_in.wr && req_in.addr == 8'h02 &&
        !(restore_req_out && restore_done_in) |=> {cfg_out.auto_reset_period,
        cfg_out.auto_threshold, cfg_out.noise_immunity_level}
        == $past(req_in.wdata[3:0])) else $error("features");
    a_reserved_zero: assert property (
        req_in.rd && req_in.addr > 8'h02 |=> rdata_out == 8'h00)
        else $error("reserved");
    a_addr_read: assert property (
        req_in.rd && req_in.addr == 8'h01 |=>
        rdata_out == {1'b0, $past(cfg_out.slave_addr)}) else $error("addr");
    // Period codes 00 and 01 both mean no limit.
    a_auto_reset_period_count: assert property (
        $stable(cfg_out.auto_reset_period) |-> auto_reset_cycles_out ==
        (cfg_out.auto_reset_period == 2'b11 ? 20 * CLK_HZ :
        cfg_out.auto_reset_period == 2'b10 ? 5 * CLK_HZ : 0))
        else $error("period");
endmodule : tch_props
bind tch_cfg_regs tch_props #(.CLK_HZ(CLK_HZ)) i_tch_props (
    .ref_clk_in(ref_clk_in), .reset_in(reset_in), .req_in(req_in),
    .rdata_out(rdata_out), .save_req_out(save_req_out),
    .save_done_in(save_done_in), .restore_req_out(restore_req_out),
    .restore_done_in(restore_done_in), .default_addr_in(default_addr_in),
    .cfg_out(cfg_out), .auto_reset_cycles_out(auto_reset_cycles_out));
`default_nettype wire

// File: tch_store_model.sv
// Storage engine model answering save or restore requests.
`timescale 1ns/100ps
`default_nettype none
module tch_store_model (
    // Clock, reset, request, slow select and completion.
    input wire logic ref_clk_in,
    input wire logic reset_in,
    input wire logic req_in,
    input wire logic slow_in,
    output logic done_out
);
    logic [4:0] cnt_reg;
    // Done pulses once the request has been counted to 2, or to 20 when slow_in is set.
    always_ff @(posedge ref_clk_in or posedge reset_in) begin
        if (reset_in) begin
            cnt_reg <= 5'h00;
            done_out <= 1'b0;
        end else begin
            done_out <= req_in && !done_out &&
                cnt_reg == (slow_in ? 5'h14 : 5'h02);
            cnt_reg <= (req_in && !done_out) ? cnt_reg + 5'h01 : 5'h00;
        end
    end
endmodule : tch_store_model
`default_nettype wire

// File: tb_top.sv
// Self-checking bench for the configuration registers.
`timescale 1ns/100ps
`default_nettype none
module testbench;
    import tch_pkg::*;
    localparam int unsigned HZ = 100;
    logic clk = 1'b0, rst = 1'b1, slow = 1'b0;
    tch_req_type req = '0;
    logic [15:0] hcs = 16'h1234, ccs = 16'h1234;
    logic [7:0] dadr = 8'h00, dfeat = 8'h00, rdata;
    logic sreq, rreq, sdone, rdone;
    tch_cfg_type cfg;
    logic [31:0] arc;
    logic [7:0] m_mode = 8'h02, m_adr = 8'h37, m_feat = 8'h02;
    int err_count = 0, n_compared = 0;
    always #2.5 clk = ~clk;
    tch_cfg_regs #(.CLK_HZ(HZ)) i_tch_cfg_regs (.ref_clk_in(clk),
        .reset_in(rst), .req_in(req), .rdata_out(rdata),
        .host_checksum_in(hcs), .calc_checksum_in(ccs),
        .save_req_out(sreq), .save_done_in(sdone),
        .restore_req_out(rreq), .restore_done_in(rdone),
        .default_addr_in(dadr), .default_feat_in(dfeat),
        .cfg_out(cfg), .auto_reset_cycles_out(arc));
    tch_store_model i_tch_store_model_s (.ref_clk_in(clk),
        .reset_in(rst), .req_in(sreq), .slow_in(slow), .done_out(sdone));
    tch_store_model i_tch_store_model_r (.ref_clk_in(clk),
        .reset_in(rst), .req_in(rreq), .slow_in(slow), .done_out(rdone));
    // Expected read data; the stored mode excludes the command bits.
    function automatic logic [7:0] exp_rd(input logic [7:0] a);
        if (a == 8'h00) return {3'h0, hcs == ccs, 1'b0, m_mode[2:0]};
        if (a == 8'h01) return m_adr;
        return (a == 8'h02) ? m_feat : 8'h00;
    endfunction
    function automatic logic [31:0] cyc(input logic [1:0] p);
        return p == 2'b11 ? 20 * HZ : p == 2'b10 ? 5 * HZ : 0;
    endfunction
    task automatic print_verdict();
        $display("errors %0d compared %0d", err_count, n_compared);
        if (err_count == 0 && n_compared > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask : print_verdict
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            err_count++;
            $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : check
    // One access, then an idle cycle so the answer has landed.
    task automatic acc(input logic w, input logic [7:0] a, d);
        req <= '{w, !w, a, d};
        @(posedge clk);
        req <= '0;
        @(posedge clk);
    endtask : acc
    task automatic read_check(input logic [7:0] a);
        acc(1'b0, a, 8'h00);
        check(rdata, exp_rd(a));
    endtask : read_check
    task automatic wait_idle();
        for (int i = 0; i < 60; i++) if (sreq || rreq) @(posedge clk);
        if (sreq || rreq) begin
            err_count++;
            print_verdict();
        end
    endtask : wait_idle
    // ==========================================
    // Main sequence.
    initial begin
        logic [7:0] a, d;
        void'($urandom(32'h579a));
        repeat (4) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        for (int i = 0; i < 4; i++) read_check(8'(i));
        acc(1'b1, 8'h00, 8'hd4);
        m_mode = 8'h04;
        read_check(8'h00);
        for (int c = 0; c < 8; c++) begin
            acc(1'b1, 8'h00, 8'(c));
            check({cfg.mode_valid, cfg.mode}, {c < 5, 3'(c)});
        end
        ccs <= 16'h4321;
        repeat (2) @(posedge clk);
        m_mode = 8'h07;
        read_check(8'h00);
        ccs <= 16'h1234;
        repeat (2) @(posedge clk);
        for (int s = 0; s < 2; s++) begin
            slow <= s[0];
            acc(1'b1, 8'h00, 8'h08);
            check(sreq, 1'b1);
            if (s == 1) acc(1'b0, 8'h00, 8'h00);
            if (s == 1) check(rdata, 8'h18);
            wait_idle();
            acc(1'b0, 8'h00, 8'h00);
            check(rdata, 8'h10);
        end
        dadr <= 8'($urandom);
        dfeat <= 8'($urandom);
        acc(1'b1, 8'h00, 8'h20);
        check({rreq, sreq}, 2'b10);
        wait_idle();
        m_adr = {1'b0, dadr[6:0]};
        m_feat = {4'h0, dfeat[3:0]};
        m_mode = 8'h00;
        acc(1'b1, 8'h00, 8'h00);
        for (int i = 1; i < 3; i++) read_check(8'(i));
        repeat (40) begin
            a = 8'($urandom_range(3));
            d = 8'($urandom);
            if (a == 8'h00) d = (d & 8'hd0) | 8'($urandom_range(4));
            if ($urandom_range(1) == 1) begin
                acc(1'b1, a, d);
                if (a == 8'h00) m_mode = d & 8'h07;
                if (a == 8'h01) m_adr = d & 8'h7f;
                if (a == 8'h02) m_feat = d & 8'h0f;
            end else begin
                read_check(a);
            end
            @(posedge clk);
            check(arc, cyc(m_feat[3:2]));
            check(cfg[3:0], m_feat[3:0]);
        end
        print_verdict();
    end
endmodule : testbench
`default_nettype wire
